/* File: rtl/audio_rx_defines.vh */
// register indexes, field positions and reset values of the audio receive control block
`ifndef AUDIO_RX_DEFINES_VH
`define AUDIO_RX_DEFINES_VH
// ----------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------
`define IDX_RX_SUBST_BYTE 14'h2761
`define IDX_RX_CTRL 14'h2762
`define IDX_RX_RPTR 14'h2763
`define IDX_RX_WPTR 14'h2764
`define IDX_RX_STATUS 14'h276A
`define IDX_RX_DMA_COUNT 14'h276B
`define IDX_TX_IRQ_ENA 14'h2770
`define IDX_RX_IRQ_ENA 14'h2771
`define IDX_DMA_IRQ_ENA 14'h2772
`define IDX_TX_IRQ_SRC 14'h2773
`define IDX_RX_IRQ_SRC 14'h2774
`define IDX_DMA_IRQ_SRC 14'h2775
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_DMA_GO 3
`define CTRL_SUBST 2
`define CTRL_PTR_RESET 1
`define CTRL_FILL 0
`define STS_FILLING 4
`define STS_PUSH 3
`define STS_POP 2
`define IRQ_EMPTY 7
`define IRQ_FULL 6
`define DMA_TX_DONE 4
`define DMA_RX_DONE 0
// ----------------------------------------
// reset values and bus codes
// ----------------------------------------
`define REG8_RESET 8'h00
`define PTR_RESET 8'h00
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0
`define FILL_LAST 8'hFF
`endif

/* File: rtl/audio_rx_fifo_irq_control.v */
// receive audio FIFO control, DMA byte feed and interrupt enable/source registers on AHB-Lite
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`include "audio_rx_defines.vh"
module audio_rx_fifo_irq_control #(
    parameter DEPTH_BITS = 8
)(
    input wire CLOCK,
    input wire NRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output reg [31:0] HRDATA,
    output wire HRESP,
    input wire [7:0] MAC_DATA,
    input wire MAC_VALID,
    output wire MAC_READY,
    input wire POP_REQ,
    output reg [7:0] POP_DATA,
    output reg POP_VALID,
    input wire TX_EMPTY,
    input wire TX_FULL,
    input wire TX_DMA_DONE,
    output wire UNDERFLOW,
    output wire OVERFLOW,
    output wire IRQ
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // wrap-around step of an 8-bit store address
    function [DEPTH_BITS-1:0] bump;
        input [DEPTH_BITS-1:0] p;
        begin
            bump = p + {{(DEPTH_BITS-1){1'b0}}, 1'b1};
        end
    endfunction

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_meta;
    reg rst_n;
    // async assert, two-flop release
    always @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [7:0] store [0:(1<<DEPTH_BITS)-1];
    reg [7:0] subst_byte;
    reg subst_en;
    reg [DEPTH_BITS-1:0] rptr;
    reg [DEPTH_BITS-1:0] wptr;
    reg rwrap;
    reg wwrap;
    reg [7:0] dma_count;
    reg [7:0] dma_left;
    reg dma_busy;
    reg filling;
    reg [DEPTH_BITS-1:0] fill_idx;
    reg push_flag;
    reg pop_flag;
    reg under;
    reg over;
    reg [1:0] tx_ena;
    reg [1:0] rx_ena;
    reg [1:0] dma_ena;
    reg [1:0] tx_src;
    reg [1:0] rx_src;
    reg [1:0] dma_src;
    reg wr_pend;
    reg [13:0] wr_idx;

    // ----------------------------------------
    // bus address phase
    // ----------------------------------------
    wire addr_ok = (HADDR[31:16] == 16'h0000) && (HADDR[1:0] == 2'b00);
    wire take = HSEL && HREADY && HTRANS[`HTRANS_NONSEQ_BIT] && addr_ok && (HSIZE == `HSIZE_WORD);
    wire [13:0] idx = HADDR[15:2];
    wire [7:0] wdat = HWDATA[7:0];
    wire wr_now = wr_pend;
    wire [7:0] rd_sel;

    // zero wait states; the slave never stalls and always answers okay
    assign HREADYOUT = 1'b1;
    assign HRESP = `HRESP_OKAY;

    // latch a write address for the following data phase
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend <= 1'b0;
            wr_idx <= 14'h0000;
        end
        else
        begin
            wr_pend <= take && HWRITE;
            wr_idx <= idx;
        end
    end

    // per-register write strobes in the data phase
    wire w_ctrl = wr_now && (wr_idx == `IDX_RX_CTRL);
    wire w_rptr = wr_now && (wr_idx == `IDX_RX_RPTR);
    wire w_wptr = wr_now && (wr_idx == `IDX_RX_WPTR);
    wire dma_go = w_ctrl && wdat[`CTRL_DMA_GO];
    wire ptr_reset = w_ctrl && wdat[`CTRL_PTR_RESET];
    wire fill_go = w_ctrl && wdat[`CTRL_FILL];

    // ----------------------------------------
    // fifo flags and transfer strobes
    // ----------------------------------------
    wire same = (rptr == wptr);
    wire empty = same && (rwrap == wwrap);
    wire full = same && (rwrap != wwrap);
    // dma feed stalls while full or filling so no byte is ever dropped
    assign MAC_READY = dma_busy && !full && !filling;
    wire push = MAC_VALID && MAC_READY;
    wire pop = POP_REQ && !filling && !empty;
    wire rx_done_evt = dma_busy && ((push && dma_left == 8'h01) || dma_left == 8'h00);
    assign UNDERFLOW = under;
    assign OVERFLOW = over;

    // ----------------------------------------
    // store and fill sequencer
    // ----------------------------------------
    // fill owns the write port; push is held off meanwhile
    always @(posedge CLOCK)
    begin
        if (filling)
            store[fill_idx] <= subst_byte;
        else if (push)
            store[wptr] <= MAC_DATA;
    end

    // fill walks all 256 locations, one per cycle
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filling <= 1'b0;
            fill_idx <= {DEPTH_BITS{1'b0}};
        end
        else if (fill_go && !filling)
        begin
            filling <= 1'b1;
            fill_idx <= {DEPTH_BITS{1'b0}};
        end
        else if (filling)
        begin
            fill_idx <= bump(fill_idx);
            if (fill_idx == `FILL_LAST)
                filling <= 1'b0;
        end
    end

    // ----------------------------------------
    // pointers
    // ----------------------------------------
    // software write of a pointer wins over a transfer in the same cycle
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rptr <= `PTR_RESET;
            wptr <= `PTR_RESET;
            rwrap <= 1'b0;
            wwrap <= 1'b0;
        end
        else if (ptr_reset)
        begin
            rptr <= `PTR_RESET;
            wptr <= `PTR_RESET;
            rwrap <= 1'b0;
            wwrap <= 1'b0;
        end
        else
        begin
            if (w_rptr)
                rptr <= wdat;
            else if (pop)
            begin
                rptr <= bump(rptr);
                if (rptr == `FILL_LAST)
                    rwrap <= ~rwrap;
            end
            if (w_wptr)
                wptr <= wdat;
            else if (push)
            begin
                wptr <= bump(wptr);
                if (wptr == `FILL_LAST)
                    wwrap <= ~wwrap;
            end
        end
    end

    // ----------------------------------------
    // pop side and activity flags
    // ----------------------------------------
    // an empty or muted pop still answers, with the substitute byte
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            POP_DATA <= `REG8_RESET;
            POP_VALID <= 1'b0;
            push_flag <= 1'b0;
            pop_flag <= 1'b0;
            under <= 1'b0;
            over <= 1'b0;
        end
        else
        begin
            POP_VALID <= POP_REQ;
            if (POP_REQ)
                POP_DATA <= (subst_en || !pop) ? subst_byte : store[rptr];
            push_flag <= push;
            pop_flag <= pop;
            if (ptr_reset)
            begin
                under <= 1'b0;
                over <= 1'b0;
            end
            // a refused transfer in the clearing cycle still counts:
            // the set is written last so it wins over the clear
            if (POP_REQ && !pop)
                under <= 1'b1;
            if (MAC_VALID && dma_busy && full)
                over <= 1'b1;
        end
    end

    // ----------------------------------------
    // receive dma
    // ----------------------------------------
    // a zero count finishes at once; go during a run restarts it
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dma_busy <= 1'b0;
            dma_left <= `REG8_RESET;
        end
        else if (dma_go)
        begin
            dma_busy <= 1'b1;
            dma_left <= dma_count;
        end
        else if (dma_busy)
        begin
            if (push)
                dma_left <= dma_left - 8'h01;
            if (rx_done_evt)
                dma_busy <= 1'b0;
        end
    end

    // ----------------------------------------
    // software registers and interrupt sources
    // ----------------------------------------
    // a hardware set in the clearing cycle wins over the clear
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            subst_byte <= `REG8_RESET;
            subst_en <= 1'b0;
            dma_count <= `REG8_RESET;
            tx_ena <= 2'h0;
            rx_ena <= 2'h0;
            dma_ena <= 2'h0;
            tx_src <= 2'h0;
            rx_src <= 2'h0;
            dma_src <= 2'h0;
        end
        else
        begin
            if (wr_now && wr_idx == `IDX_RX_SUBST_BYTE)
                subst_byte <= wdat;
            if (w_ctrl)
                subst_en <= wdat[`CTRL_SUBST];
            if (wr_now && wr_idx == `IDX_RX_DMA_COUNT)
                dma_count <= wdat;
            if (wr_now && wr_idx == `IDX_TX_IRQ_ENA)
                tx_ena <= {wdat[`IRQ_EMPTY], wdat[`IRQ_FULL]};
            if (wr_now && wr_idx == `IDX_RX_IRQ_ENA)
                rx_ena <= {wdat[`IRQ_EMPTY], wdat[`IRQ_FULL]};
            if (wr_now && wr_idx == `IDX_DMA_IRQ_ENA)
                dma_ena <= {wdat[`DMA_TX_DONE], wdat[`DMA_RX_DONE]};
            tx_src <= (tx_src & ~((wr_now && wr_idx == `IDX_TX_IRQ_SRC) ?
                {wdat[`IRQ_EMPTY], wdat[`IRQ_FULL]} : 2'h0))
                | ({TX_EMPTY, TX_FULL} & tx_ena);
            rx_src <= (rx_src & ~((wr_now && wr_idx == `IDX_RX_IRQ_SRC) ?
                {wdat[`IRQ_EMPTY], wdat[`IRQ_FULL]} : 2'h0))
                | ({empty, full} & rx_ena);
            dma_src <= (dma_src & ~((wr_now && wr_idx == `IDX_DMA_IRQ_SRC) ?
                {wdat[`DMA_TX_DONE], wdat[`DMA_RX_DONE]} : 2'h0))
                | ({TX_DMA_DONE, rx_done_evt});
        end
    end

    assign IRQ = |(tx_src & tx_ena) | |(rx_src & rx_ena) | |(dma_src & dma_ena);

    // ----------------------------------------
    // read mux, captured in the address phase
    // ----------------------------------------
    // write-only control bits read back as zero; unmapped indexes read zero
    assign rd_sel =
        (idx == `IDX_RX_SUBST_BYTE) ? subst_byte :
        (idx == `IDX_RX_CTRL) ? ({7'h00, subst_en} << `CTRL_SUBST) :
        (idx == `IDX_RX_RPTR) ? rptr :
        (idx == `IDX_RX_WPTR) ? wptr :
        (idx == `IDX_RX_STATUS) ? (({7'h00, filling} << `STS_FILLING) | ({7'h00, push_flag} << `STS_PUSH)
            | ({7'h00, pop_flag} << `STS_POP)) :
        (idx == `IDX_RX_DMA_COUNT) ? dma_count :
        (idx == `IDX_TX_IRQ_ENA) ? {tx_ena, 6'h00} :
        (idx == `IDX_RX_IRQ_ENA) ? {rx_ena, 6'h00} :
        (idx == `IDX_DMA_IRQ_ENA) ? {3'h0, dma_ena[1], 3'h0, dma_ena[0]} :
        (idx == `IDX_TX_IRQ_SRC) ? {tx_src, 6'h00} :
        (idx == `IDX_RX_IRQ_SRC) ? {rx_src, 6'h00} :
        (idx == `IDX_DMA_IRQ_SRC) ? {3'h0, dma_src[1], 3'h0, dma_src[0]} :
        8'h00;

    // read data is fixed in the address phase; a write landing at that same edge is not yet seen
    always @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            HRDATA <= 32'h00000000;
        else if (take && !HWRITE)
            HRDATA <= {24'h000000, rd_sel};
    end
endmodule

/* File: testbench/audio_rx_sva.sv */
// assertion checker for the audio receive control block
`timescale 1ns/10ps
`include "audio_rx_defines.vh"
module audio_rx_sva (
    input wire CLOCK,
    input wire NRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire MAC_VALID,
    input wire MAC_READY,
    input wire POP_REQ,
    input wire POP_VALID,
    input wire UNDERFLOW,
    input wire OVERFLOW
);
    reg wph;
    reg [13:0] idx;
    reg [7:0] cnt;
    wire ctl = wph && idx == `IDX_RX_CTRL;
    // bus ready is always high, so each address phase is followed at once by its data phase
    always @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            wph <= 1'h0;
            idx <= 14'h0000;
            cnt <= 8'h00;
        end
        else
        begin
            if (wph && idx == `IDX_RX_DMA_COUNT)
                cnt <= HWDATA[7:0];
            wph <= HSEL && HTRANS[1] && HWRITE;
            idx <= HADDR[15:2];
        end
    end
    // ------
    // properties
    // ------
    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    a_pop_answer: assert property (POP_REQ |=> POP_VALID)
        else $error("pop not answered");
    a_pop_single: assert property (!POP_REQ |=> !POP_VALID)
        else $error("pop answer without request");
    a_go_starts: assert property (ctl && HWDATA[3] && cnt != 8'h00 |-> ##[1:2] MAC_READY)
        else $error("dma did not start");
    a_fill_blocks: assert property (ctl && HWDATA[0] |=> !MAC_READY [*8])
        else $error("push taken during fill");
    a_clear_flow: assert property (ctl && HWDATA[1] && !POP_REQ |=> !UNDERFLOW)
        else $error("underflow not cleared");
    a_under_held: assert property (UNDERFLOW && !(ctl && HWDATA[1]) |=> UNDERFLOW)
        else $error("underflow dropped");
    a_under_cause: assert property ($rose(UNDERFLOW) |-> $past(POP_REQ))
        else $error("underflow without pop");
    a_over_cause: assert property ($rose(OVERFLOW) |-> $past(MAC_VALID) && !$past(MAC_READY))
        else $error("overflow without refused byte");
    c_pop: cover property (POP_VALID);
    c_over: cover property ($rose(OVERFLOW));
    c_go: cover property (ctl && HWDATA[3]);
endmodule

/* File: testbench/mac_rx_source.sv */
// behavioural model of the MAC receive FIFO feeding the DMA
`timescale 1ns/10ps
module mac_rx_source (
    input wire clk,
    input wire rst_n,
    input wire ready,
    input wire stall,
    output reg valid,
    output wire [7:0] data
);
    reg [7:0] head;
    // idle lines show the inverse so a stale byte is never mistaken for a fresh one
    assign data = valid ? head : ~head;
    // a byte once offered stays until taken; a stall only delays the next offer
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head <= 8'h10;
            valid <= 1'h0;
        end
        else
        begin
            if (valid && ready)
                head <= head + 8'h01;
            valid <= (valid && !ready) || !stall;
        end
    end
endmodule

/* File: testbench/test_audio_rx_fifo_irq_control.sv */
// self-checking bench for the audio receive control block
`timescale 1ns/10ps
`include "audio_rx_defines.vh"
module test_audio_rx_fifo_irq_control;
    reg CLOCK = 1'h0, NRST = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, POP_REQ = 1'h0, rd_dp = 1'h0;
    reg TX_EMPTY = 1'h0, TX_FULL = 1'h0, TX_DMA_DONE = 1'h0, stall = 1'h0, calm = 1'h0;
    reg [1:0] HTRANS = 2'h0;
    reg [2:0] HSIZE = 3'h2;
    reg [31:0] HADDR = 32'h00000000, HWDATA = 32'h00000000, rnd = 32'h0000F9E6;
    reg [7:0] rd_q[$], pop_q[$], s;
    wire HREADYOUT, HRESP, MAC_VALID, MAC_READY, POP_VALID, UNDERFLOW, OVERFLOW, IRQ;
    wire [31:0] HRDATA;
    wire [7:0] MAC_DATA, POP_DATA;
    integer err_total = 0, check_count = 0, cyc = 0, i;
    audio_rx_fifo_irq_control u_audio_rx_fifo_irq_control (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .MAC_DATA(MAC_DATA), .MAC_VALID(MAC_VALID),
        .MAC_READY(MAC_READY), .POP_REQ(POP_REQ), .POP_DATA(POP_DATA), .POP_VALID(POP_VALID),
        .TX_EMPTY(TX_EMPTY), .TX_FULL(TX_FULL), .TX_DMA_DONE(TX_DMA_DONE), .UNDERFLOW(UNDERFLOW),
        .OVERFLOW(OVERFLOW), .IRQ(IRQ));
    mac_rx_source u_mac_rx_source (.clk(CLOCK), .rst_n(NRST), .ready(MAC_READY), .stall(stall),
        .valid(MAC_VALID), .data(MAC_DATA));
    // 50 MHz system clock
    initial
    begin
        forever #10 CLOCK = ~CLOCK;
    end
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task test_done;
    begin
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    // one single transfer; ready is waited for, never assumed
    task bus(input w, input [13:0] x, input [7:0] d, input [2:0] z);
    begin
        @(posedge CLOCK);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HSIZE <= z;
        HADDR <= {16'h0000, x, 2'h0};
        @(posedge CLOCK);
        while (HREADYOUT !== 1'h1)
            @(posedge CLOCK);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h000000, d};
        rd_dp <= !w;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'h1)
            @(posedge CLOCK);
        rd_dp <= 1'h0;
    end
    endtask
    task wr(input [13:0] x, input [7:0] d);
        bus(1'h1, x, d, `HSIZE_WORD);
    endtask
    task rd(input [13:0] x, input [7:0] e);
    begin
        rd_q.push_back(e);
        bus(1'h0, x, 8'h00, `HSIZE_WORD);
    end
    endtask
    task pop(input [7:0] e);
    begin
        pop_q.push_back(e);
        @(posedge CLOCK);
        POP_REQ <= 1'h1;
        @(posedge CLOCK);
        POP_REQ <= 1'h0;
    end
    endtask
    // results are matched to the oldest note; random stalls of the far side; hang guard
    always @(posedge CLOCK)
    begin
        cyc = cyc + 1;
        rnd <= lfsr(rnd);
        stall <= rnd[0] & rnd[3] & !calm;
        if (rd_dp === 1'h1)
            chk(HRDATA, {24'h000000, rd_q.pop_front()});
        if (POP_VALID === 1'h1)
            chk(POP_DATA, {24'h000000, pop_q.pop_front()});
        if (cyc == 5000)
        begin
            err_total = err_total + 1;
            test_done;
        end
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge CLOCK);
        NRST <= 1'h1;
        repeat (3) @(posedge CLOCK);
        for (i = 14'h2761; i <= 14'h2775; i = i + 1)
            rd(i[13:0], 8'h00);
        chk(HRESP, `HRESP_OKAY);
        wr(`IDX_RX_IRQ_ENA, 8'hC0);
        rd(`IDX_RX_IRQ_SRC, 8'h80);
        @(negedge CLOCK);
        chk(IRQ, 1'h1);
        wr(`IDX_RX_IRQ_ENA, 8'h00);
        @(negedge CLOCK);
        chk(IRQ, 1'h0);
        wr(`IDX_RX_IRQ_SRC, 8'h80);
        rd(`IDX_RX_IRQ_SRC, 8'h00);
        wr(`IDX_TX_IRQ_ENA, 8'hC0);
        TX_EMPTY <= 1'h1;
        rd(`IDX_TX_IRQ_SRC, 8'h80);
        TX_EMPTY <= 1'h0;
        TX_FULL <= 1'h1;
        rd(`IDX_TX_IRQ_SRC, 8'hC0);
        TX_FULL <= 1'h0;
        wr(`IDX_TX_IRQ_SRC, 8'hC0);
        rd(`IDX_TX_IRQ_SRC, 8'h00);
        rd(`IDX_TX_IRQ_ENA, 8'hC0);
        s = rnd[7:0] | 8'h80;
        wr(`IDX_RX_SUBST_BYTE, s);
        bus(1'h1, `IDX_RX_SUBST_BYTE, ~s, 3'h0);
        rd(`IDX_RX_SUBST_BYTE, s);
        wr(`IDX_DMA_IRQ_ENA, 8'h11);
        rd(`IDX_DMA_IRQ_ENA, 8'h11);
        wr(`IDX_RX_DMA_COUNT, 8'h04);
        wr(`IDX_RX_CTRL, 8'h08);
        repeat (40) @(posedge CLOCK);
        TX_DMA_DONE <= 1'h1;
        @(posedge CLOCK);
        TX_DMA_DONE <= 1'h0;
        rd(`IDX_RX_CTRL, 8'h00);
        rd(`IDX_RX_WPTR, 8'h04);
        rd(`IDX_DMA_IRQ_SRC, 8'h11);
        wr(`IDX_DMA_IRQ_SRC, 8'h11);
        pop(8'h10);
        pop(8'h11);
        wr(`IDX_RX_CTRL, 8'h04);
        rd(`IDX_RX_CTRL, 8'h04);
        pop(s);
        wr(`IDX_RX_CTRL, 8'h00);
        fork
            pop(8'h13);
            begin
                @(posedge CLOCK);
                rd(`IDX_RX_STATUS, 8'h04);
            end
        join
        pop(s);
        @(negedge CLOCK);
        chk(UNDERFLOW, 1'h1);
        wr(`IDX_RX_CTRL, 8'h02);
        rd(`IDX_RX_RPTR, 8'h00);
        wr(`IDX_RX_DMA_COUNT, 8'h00);
        wr(`IDX_RX_CTRL, 8'h09);
        rd(`IDX_RX_STATUS, 8'h10);
        repeat (260) @(posedge CLOCK);
        rd(`IDX_RX_STATUS, 8'h00);
        wr(`IDX_RX_SUBST_BYTE, ~s);
        wr(`IDX_RX_WPTR, 8'h05);
        rd(`IDX_RX_WPTR, 8'h05);
        pop(s);
        wr(`IDX_RX_CTRL, 8'h02);
        wr(`IDX_RX_DMA_COUNT, 8'hFF);
        calm <= 1'h1;
        wr(`IDX_RX_CTRL, 8'h08);
        rd(`IDX_RX_STATUS, 8'h08);
        repeat (600) @(posedge CLOCK);
        wr(`IDX_RX_DMA_COUNT, 8'h02);
        wr(`IDX_RX_CTRL, 8'h08);
        repeat (20) @(negedge CLOCK);
        chk(OVERFLOW, 1'h1);
        test_done;
    end
endmodule
bind audio_rx_fifo_irq_control audio_rx_sva u_audio_rx_sva (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .MAC_VALID(MAC_VALID),
    .MAC_READY(MAC_READY), .POP_REQ(POP_REQ), .POP_VALID(POP_VALID), .UNDERFLOW(UNDERFLOW),
    .OVERFLOW(OVERFLOW));
